/* hw/tcim_top.sv */
`timescale 1ns/1ps

module tcim_top (
   // Clock and reset
   input  wire logic                            CORE_CLK,
   input  wire logic                            RESET_N,
   // Write address channel
   input  wire logic [tcim_pkg::ADDR_W-1:0]     AWADDR,
   input  wire logic                            AWVALID,
   output logic                                 AWREADY,
   // Write data channel
   input  wire logic [tcim_pkg::DATA_W-1:0]     WDATA,
   input  wire logic [tcim_pkg::DATA_W/8-1:0]   WSTRB,
   input  wire logic                            WVALID,
   output logic                                 WREADY,
   // Write response channel
   output tcim_pkg::tcim_resp_type              BRESP,
   output logic                                 BVALID,
   input  wire logic                            BREADY,
   // Read address channel
   input  wire logic [tcim_pkg::ADDR_W-1:0]     ARADDR,
   input  wire logic                            ARVALID,
   output logic                                 ARREADY,
   // Read data channel
   output logic [tcim_pkg::DATA_W-1:0]          RDATA,
   output tcim_pkg::tcim_resp_type              RRESP,
   output logic                                 RVALID,
   input  wire logic                            RREADY,
   // Event pulses from the counter datapath
   input  wire tcim_pkg::tcim_src_type          EVENT_PULSE,
   // Channel interrupt request
   output logic                                 IRQ
);

   function automatic logic reg_hit(
      input logic [tcim_pkg::ADDR_W-1:0] addr,
      input logic [tcim_pkg::ADDR_W-1:0] off
   );
      reg_hit = addr[tcim_pkg::ADDR_W-1:tcim_pkg::ALIGN_LSB]
             == off[tcim_pkg::ADDR_W-1:tcim_pkg::ALIGN_LSB];
   endfunction

   // Sources whose events and disables count in the given mode
   function automatic tcim_pkg::tcim_src_type mode_sources(input logic wave);
      mode_sources = tcim_pkg::SRC_ANY_MODE
                   | (wave ? tcim_pkg::SRC_WAVE : tcim_pkg::SRC_CAPT);
   endfunction

   // Write path state
   logic                            aw_held_q, aw_held_d;
   logic                            w_held_q,  w_held_d;
   logic [tcim_pkg::ADDR_W-1:0]     awaddr_q;
   logic [tcim_pkg::DATA_W-1:0]     wdata_q;
   logic [tcim_pkg::DATA_W/8-1:0]   wstrb_q;
   logic                            awready_q, wready_q;
   logic                            bvalid_q,  bvalid_d;
   tcim_pkg::tcim_resp_type         bresp_q,   bresp_d;

   // Read path state
   logic                            arready_q;
   logic                            rvalid_q,  rvalid_d;
   logic [tcim_pkg::DATA_W-1:0]     rdata_q,   rdata_d;
   tcim_pkg::tcim_resp_type         rresp_q,   rresp_d;

   // Block state
   tcim_pkg::tcim_src_type          mask_q,    mask_d;
   tcim_pkg::tcim_src_type          flags_q,   flags_d;
   logic                            wave_q,    wave_d;
   logic                            irq_q;

   // Handshakes
   wire logic aw_take  = AWVALID & awready_q;
   wire logic w_take   = WVALID & wready_q;
   wire logic do_write = aw_held_q & w_held_q & ~bvalid_q;
   wire logic ar_take  = ARVALID & arready_q;

   assign aw_held_d = (aw_held_q & ~do_write) | aw_take;
   assign w_held_d  = (w_held_q & ~do_write) | w_take;
   assign bvalid_d  = do_write | (bvalid_q & ~BREADY);
   assign rvalid_d  = ar_take | (rvalid_q & ~RREADY);

   // Write decode
   wire logic wr_en_hit   = reg_hit(awaddr_q, tcim_pkg::OFF_ENABLE);
   wire logic wr_dis_hit  = reg_hit(awaddr_q, tcim_pkg::OFF_DISABLE);
   wire logic wr_mode_hit = reg_hit(awaddr_q, tcim_pkg::OFF_MODE);
   wire logic wr_ok       = wr_en_hit | wr_dis_hit | wr_mode_hit;
   wire logic wr_lane0    = do_write & wstrb_q[0];

   wire tcim_pkg::tcim_src_type wr_bits =
      tcim_pkg::tcim_src_type'(wdata_q[tcim_pkg::SRC_N-1:0]);

   // Sources that a disable may clear in the current mode
   wire tcim_pkg::tcim_src_type dis_allowed =
      mode_sources(wave_q);

   wire tcim_pkg::tcim_src_type set_bits =
      (wr_lane0 & wr_en_hit) ? wr_bits
                             : tcim_pkg::SRC_NONE;
   wire tcim_pkg::tcim_src_type clr_bits =
      (wr_lane0 & wr_dis_hit) ? (wr_bits & dis_allowed)
                              : tcim_pkg::SRC_NONE;

   assign mask_d  = (mask_q | set_bits) & ~clr_bits;
   assign wave_d  = (wr_lane0 & wr_mode_hit)
                  ? wdata_q[tcim_pkg::MODE_WAVE_BIT] : wave_q;
   assign bresp_d = do_write ? (wr_ok ? tcim_pkg::RESP_OKAY
                                      : tcim_pkg::RESP_SLVERR)
                             : bresp_q;

   // Read decode
   wire logic rd_en_hit   = reg_hit(ARADDR, tcim_pkg::OFF_ENABLE);
   wire logic rd_dis_hit  = reg_hit(ARADDR, tcim_pkg::OFF_DISABLE);
   wire logic rd_mask_hit = reg_hit(ARADDR, tcim_pkg::OFF_MASK);
   wire logic rd_stat_hit = reg_hit(ARADDR, tcim_pkg::OFF_STATUS);
   wire logic rd_mode_hit = reg_hit(ARADDR, tcim_pkg::OFF_MODE);
   wire logic rd_ok       = rd_en_hit | rd_dis_hit | rd_mask_hit
                          | rd_stat_hit | rd_mode_hit;

   // Upper bits read zero; strobe registers read as zero
   wire logic [tcim_pkg::DATA_W-1:0] rd_mask_word =
      {{(tcim_pkg::DATA_W-tcim_pkg::SRC_N){1'b0}}, mask_q};
   wire logic [tcim_pkg::DATA_W-1:0] rd_stat_word =
      {{(tcim_pkg::DATA_W-tcim_pkg::SRC_N){1'b0}}, flags_q};
   wire logic [tcim_pkg::DATA_W-1:0] rd_mode_word =
      {{(tcim_pkg::DATA_W-1){1'b0}}, wave_q};
   wire logic [tcim_pkg::DATA_W-1:0] rd_word =
        rd_mask_hit ? rd_mask_word
      : rd_stat_hit ? rd_stat_word
      : rd_mode_hit ? rd_mode_word
      : tcim_pkg::DATA_ZERO;

   assign rdata_d = ar_take ? rd_word : rdata_q;
   assign rresp_d = ar_take ? (rd_ok ? tcim_pkg::RESP_OKAY
                                     : tcim_pkg::RESP_SLVERR)
                            : rresp_q;

   // Flags: events qualified by mode; a new event wins over the read clear
   wire logic stat_rd = ar_take & rd_stat_hit;
   wire tcim_pkg::tcim_src_type ev_ok =
      EVENT_PULSE & mode_sources(wave_q);
   wire tcim_pkg::tcim_src_type rd_clr =
      stat_rd ? flags_q : tcim_pkg::SRC_NONE;
   assign flags_d = (flags_q & ~rd_clr) | ev_ok;

   wire logic irq_d = |(flags_q & mask_q);

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= tcim_pkg::RESP_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         awready_q <= ~aw_held_d;
         wready_q  <= ~w_held_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (aw_take) begin
         awaddr_q <= AWADDR;
      end
      if (w_take) begin
         wdata_q <= WDATA;
         wstrb_q <= WSTRB;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= tcim_pkg::DATA_ZERO;
         rresp_q   <= tcim_pkg::RESP_OKAY;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         mask_q  <= tcim_pkg::SRC_NONE;
         flags_q <= tcim_pkg::SRC_NONE;
         wave_q  <= tcim_pkg::MODE_RST;
         irq_q   <= 1'b0;
      end else begin
         mask_q  <= mask_d;
         flags_q <= flags_d;
         wave_q  <= wave_d;
         irq_q   <= irq_d;
      end
   end

   assign AWREADY = awready_q;
   assign WREADY  = wready_q;
   assign BVALID  = bvalid_q;
   assign BRESP   = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID  = rvalid_q;
   assign RDATA   = rdata_q;
   assign RRESP   = rresp_q;
   assign IRQ     = irq_q;

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   wire logic en_wr  = wr_lane0 & wr_en_hit;
   wire logic dis_wr = wr_lane0 & wr_dis_hit;

   a_enable_sets: assert property (
      en_wr |=> (mask_q & $past(wr_bits)) == $past(wr_bits))
      else $error("enable write did not set mask bits");

   a_enable_keeps: assert property (
      en_wr |=> ($past(mask_q) & ~mask_q) == tcim_pkg::SRC_NONE)
      else $error("enable write cleared a mask bit");

   a_disable_any: assert property (
      dis_wr |=> (mask_q & $past(wr_bits) & tcim_pkg::SRC_ANY_MODE)
                 == tcim_pkg::SRC_NONE)
      else $error("disable missed an any-mode source");

   a_disable_capt: assert property (
      dis_wr && !wave_q |=> (mask_q & $past(wr_bits) & tcim_pkg::SRC_CAPT)
                            == tcim_pkg::SRC_NONE)
      else $error("disable missed a capture source");

   a_disable_wave: assert property (
      dis_wr && wave_q |=> (mask_q & $past(wr_bits) & tcim_pkg::SRC_WAVE)
                           == tcim_pkg::SRC_NONE)
      else $error("disable missed a waveform source");

   a_disable_guard: assert property (
      dis_wr |=> (mask_q & ~$past(dis_allowed)) ==
                 ($past(mask_q) & ~$past(dis_allowed)))
      else $error("disable touched a source outside its mode");

   a_view_reads: assert property (
      ar_take && rd_mask_hit |=> RVALID && RDATA == $past(rd_mask_word))
      else $error("mask view read returned wrong data");

   a_status_clear: assert property (
      stat_rd |=> (flags_q & ~$past(ev_ok)) == tcim_pkg::SRC_NONE)
      else $error("status read left a reported flag set");

   a_flag_sets: assert property (
      ev_ok != tcim_pkg::SRC_NONE |=> (flags_q & $past(ev_ok)) == $past(ev_ok))
      else $error("qualified event did not set its flag");

   a_irq_level: assert property (
      ##1 IRQ == $past(|(flags_q & mask_q)))
      else $error("interrupt level disagrees with flags and mask");

   a_bresp_hold: assert property (
      BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped before taken");

   a_view_readonly: assert property (
      do_write && !wr_en_hit && !wr_dis_hit |=> mask_q == $past(mask_q))
      else $error("write outside the strobes changed the mask");

   a_lane_gate: assert property (
      do_write && !wstrb_q[0] |=> mask_q == $past(mask_q)
                                  && wave_q == $past(wave_q))
      else $error("write without lane zero changed state");

   a_upper_zero: assert property (
      RVALID |-> (RDATA >> tcim_pkg::SRC_N) == tcim_pkg::DATA_ZERO)
      else $error("unused read bits not zero");

   a_status_reports: assert property (
      stat_rd |=> RVALID && RDATA[tcim_pkg::SRC_N-1:0] == $past(flags_q))
      else $error("status read returned wrong flags");

   a_irq_drops: assert property (
      stat_rd && ev_ok == tcim_pkg::SRC_NONE |=> ##1 !IRQ)
      else $error("interrupt stayed high after status read");

   a_mode_blocks: assert property (
      ##1 (flags_q & ~$past(flags_q) & ~$past(dis_allowed))
          == tcim_pkg::SRC_NONE)
      else $error("event outside its mode set a flag");

   a_aw_refused: assert property (
      aw_held_q |-> !AWREADY)
      else $error("address accepted while one is held");

   a_w_refused: assert property (
      w_held_q |-> !WREADY)
      else $error("data accepted while a word is held");

   a_ar_refused: assert property (
      RVALID |-> !ARREADY)
      else $error("read accepted while data pending");

   a_write_answer: assert property (
      do_write |=> BVALID)
      else $error("write applied without a response");

   a_write_error: assert property (
      do_write && !wr_ok |=> BRESP == tcim_pkg::RESP_SLVERR)
      else $error("unmapped write not answered with an error");

   a_read_answer: assert property (
      ar_take |=> RVALID)
      else $error("read taken without data following");

   a_read_error: assert property (
      ar_take && !rd_ok |=> RRESP == tcim_pkg::RESP_SLVERR
                            && RDATA == tcim_pkg::DATA_ZERO)
      else $error("unmapped read not answered with an error");

   c_enable_then_irq: cover property (en_wr ##[1:20] IRQ);
   c_status_clear:    cover property (stat_rd
                                      && flags_q != tcim_pkg::SRC_NONE);
   c_disable_wave:    cover property (dis_wr && wave_q);
   c_set_beats_clear: cover property (stat_rd
                         && (ev_ok & flags_q) != tcim_pkg::SRC_NONE);
   c_read_with_irq:   cover property (stat_rd && IRQ);

endmodule

/* hw/tcim_pkg.sv */
package tcim_pkg;

   // Bus geometry
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int SRC_N  = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DISABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_MODE    = 8'h10;

   // Word alignment: low address bits ignored by decode
   localparam int ALIGN_LSB = 2;

   // Mode register field
   localparam int   MODE_WAVE_BIT = 0;
   localparam logic MODE_RST      = 1'b0;

   // Shared source layout, bit 7 first
   typedef struct packed {
      logic external_trigger_event;
      logic capture_load_b;
      logic capture_load_a;
      logic compare_hit_c;
      logic compare_hit_b;
      logic compare_hit_a;
      logic load_overrun;
      logic counter_overflow;
   } tcim_src_type;

   localparam tcim_src_type SRC_NONE = 8'h00;

   // Sources live in any mode, capture mode only, waveform mode only
   localparam tcim_src_type SRC_ANY_MODE = 8'h91;
   localparam tcim_src_type SRC_CAPT     = 8'h62;
   localparam tcim_src_type SRC_WAVE     = 8'h0C;

   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_SLVERR = 2'b10
   } tcim_resp_type;

   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage

/* tb/tcim_top_tb.sv */
`timescale 1ns/1ps

module tcim_top_tb;
   localparam logic [1:0] OK    = 2'b00;
   localparam logic [1:0] SLV   = 2'b10;
   localparam int         LIMIT = 8000;

   logic                              CORE_CLK    = 1'b0;
   logic                              RESET_N     = 1'b0;
   logic [tcim_pkg::ADDR_W-1:0]       AWADDR      = 8'h00;
   logic                              AWVALID     = 1'b0;
   logic                              AWREADY;
   logic [tcim_pkg::DATA_W-1:0]       WDATA       = 32'h0000_0000;
   logic [3:0]                        WSTRB       = 4'hF;
   logic                              WVALID      = 1'b0;
   logic                              WREADY;
   tcim_pkg::tcim_resp_type           BRESP;
   logic                              BVALID;
   logic                              BREADY      = 1'b1;
   logic [tcim_pkg::ADDR_W-1:0]       ARADDR      = 8'h00;
   logic                              ARVALID     = 1'b0;
   logic                              ARREADY;
   logic [tcim_pkg::DATA_W-1:0]       RDATA;
   tcim_pkg::tcim_resp_type           RRESP;
   logic                              RVALID;
   logic                              RREADY      = 1'b1;
   tcim_pkg::tcim_src_type            EVENT_PULSE = 8'h00;
   logic                              IRQ;
   int                                miscompares = 0;
   int                                comparisons = 0;
   int                                cycles      = 0;
   int                                seed        = 32'h69a7;
   logic [33:0]                       rq[$];
   logic [1:0]                        wq[$];

   tcim_top u_tcim_top (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .EVENT_PULSE(EVENT_PULSE), .IRQ(IRQ));

   always #2 CORE_CLK = ~CORE_CLK;

   task automatic finish_test();
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic report(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_rd(input logic [33:0] exp);
      report({RRESP, RDATA}, exp);
   endtask

   task automatic cmp_wr(input logic [1:0] exp);
      report({32'h0000_0000, BRESP}, {32'h0000_0000, exp});
   endtask

   task automatic cmp_irq(input logic exp);
      repeat (3) @(posedge CORE_CLK);
      report({33'h0_0000_0000, IRQ}, {33'h0_0000_0000, exp});
   endtask

   // Results are checked here as they appear on the bus
   always @(posedge CORE_CLK) begin
      if (RVALID === 1'b1 && RREADY) begin
         cmp_rd(rq.pop_front());
      end
      if (BVALID === 1'b1 && BREADY) begin
         cmp_wr(wq.pop_front());
      end
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] e);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      wq.push_back(e);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge CORE_CLK);
         if (!aw_ok && AWREADY === 1'b1) begin
            aw_ok = 1'b1;
            AWVALID <= 1'b0;
         end
         if (!w_ok && WREADY === 1'b1) begin
            w_ok = 1'b1;
            WVALID <= 1'b0;
         end
      end
      do @(posedge CORE_CLK); while (BVALID !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      rq.push_back({e, d});
      ARADDR <= a;
      ARVALID <= 1'b1;
      do @(posedge CORE_CLK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      do @(posedge CORE_CLK); while (RVALID !== 1'b1);
   endtask

   initial begin
      logic [31:0] en;
      logic [31:0] dis;
      logic [7:0]  ev;
      logic [7:0]  mask;
      logic [7:0]  flags;
      logic [7:0]  valid;
      logic        mode;
      mask = 8'h00;
      repeat (2) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      rd(tcim_pkg::OFF_MASK, 32'h0000_0000, OK);
      rd(tcim_pkg::OFF_STATUS, 32'h0000_0000, OK);
      rd(tcim_pkg::OFF_MODE, 32'h0000_0000, OK);
      wr(tcim_pkg::OFF_MASK, 32'h0000_00FF, 4'hF, SLV);
      wr(tcim_pkg::OFF_STATUS, 32'h0000_00FF, 4'hF, SLV);
      wr(8'h20, 32'h0000_00FF, 4'hF, SLV);
      rd(8'h14, 32'h0000_0000, SLV);
      wr(tcim_pkg::OFF_ENABLE, 32'h0000_00FF, 4'hE, OK);
      wr(tcim_pkg::OFF_ENABLE, 32'hFFFF_FF00, 4'hF, OK);
      rd(tcim_pkg::OFF_MASK, 32'h0000_0000, OK);
      // Random mode, strobes and events against a reference mask
      for (int i = 0; i < 40; i++) begin
         mode = 1'($random(seed));
         en = $random(seed);
         dis = $random(seed);
         ev = 8'($random(seed));
         valid = tcim_pkg::SRC_ANY_MODE |
                 (mode ? tcim_pkg::SRC_WAVE : tcim_pkg::SRC_CAPT);
         wr(tcim_pkg::OFF_MODE, {31'h0000_0000, mode}, 4'hF, OK);
         rd(tcim_pkg::OFF_MODE, {31'h0000_0000, mode}, OK);
         mask = mask | en[7:0];
         wr(tcim_pkg::OFF_ENABLE, en, 4'hF, OK);
         rd(tcim_pkg::OFF_MASK, {24'h00_0000, mask}, OK);
         mask = mask & ~(dis[7:0] & valid);
         wr(tcim_pkg::OFF_DISABLE, dis, 4'hF, OK);
         rd(tcim_pkg::OFF_MASK, {24'h00_0000, mask}, OK);
         flags = ev & valid;
         EVENT_PULSE <= ev;
         @(posedge CORE_CLK);
         EVENT_PULSE <= 8'h00;
         cmp_irq(|(flags & mask));
         rd(tcim_pkg::OFF_STATUS, {24'h00_0000, flags}, OK);
         cmp_irq(1'b0);
         rd(tcim_pkg::OFF_STATUS, 32'h0000_0000, OK);
      end
      // Event in the cycle of a clearing read survives it
      EVENT_PULSE <= 8'h01;
      @(posedge CORE_CLK);
      EVENT_PULSE <= 8'h10;
      rd(tcim_pkg::OFF_STATUS, 32'h0000_0001, OK);
      EVENT_PULSE <= 8'h00;
      rd(tcim_pkg::OFF_STATUS, 32'h0000_0010, OK);
      // Strobe registers read as zero
      rd(tcim_pkg::OFF_ENABLE, 32'h0000_0000, OK);
      rd(tcim_pkg::OFF_DISABLE, 32'h0000_0000, OK);
      // Reset in mid-run clears mask, flags, mode and interrupt
      wr(tcim_pkg::OFF_MODE, 32'h0000_0001, 4'hF, OK);
      wr(tcim_pkg::OFF_ENABLE, 32'h0000_00FF, 4'hF, OK);
      EVENT_PULSE <= 8'h80;
      @(posedge CORE_CLK);
      EVENT_PULSE <= 8'h00;
      cmp_irq(1'b1);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      cmp_irq(1'b0);
      rd(tcim_pkg::OFF_MASK, 32'h0000_0000, OK);
      rd(tcim_pkg::OFF_STATUS, 32'h0000_0000, OK);
      rd(tcim_pkg::OFF_MODE, 32'h0000_0000, OK);
      finish_test();
   end
endmodule
